//--- isp_pixel_port.sv
// Sensor pixel port: enable, frame and line timing, pixel bus, config slave
// Operation
// - Frame timing and pixel outputs operate only while sensor_enable is high; the I2C slave runs regardless
// - All timing from the one master clock
// - Reset input is active low
// - Frame pulse at each frame start
// - Valid strobe high exactly with pixel data
// - Configuration via I2C slave on data line
// - Frame pulse high for vertical blanking count
`timescale 1ns/100ps
`include "isp_map.svh"
module isp_pixel_port #(
	parameter int WIN_W = `ISP_WIN_WIDTH,
	parameter int WIN_H = `ISP_WIN_HEIGHT,
	parameter int ARRAY_W = `ISP_ARRAY_WIDTH,
	parameter int HBLANK = `ISP_HBLANK_DEF,
	parameter int VBLANK = `ISP_VBLANK_DEF
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic sensor_enable,
	input wire logic i2c_scl_in,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe,
	output isp_pkg::isp_pixel_t pixel_bus,
	output logic pixel_valid_strobe,
	output logic frame_sync,
	output logic [7:0] cfg_last_byte
);
	import isp_pkg::*;
	initial
	begin
		if (WIN_W < 1 || WIN_W > ARRAY_W || WIN_H < 1 || VBLANK < 1 || HBLANK < 0)
			$error("isp_pixel_port: bad geometry");
	end
	localparam int LOWLEN = HBLANK + ARRAY_W - WIN_W;
	logic en_s, scl_s, sda_s;
	// Pins are asynchronous to the core clock
	// I2C lines idle high, enable idles low
	isp_sync #(.WIDTH(3), .RESET_VAL(3'h3)) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.async_in({sensor_enable, i2c_scl_in, i2c_sda_in}),
		.sync_out({en_s, scl_s, sda_s})
	);
	isp_state_t state_q;
	logic [15:0] cnt_q;
	logic [15:0] row_q;
	// Frame timing; disabling ends any frame at once
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= ISP_IDLE;
			cnt_q <= 16'h0000;
			row_q <= 16'h0000;
		end
		else if (!en_s)
		begin
			state_q <= ISP_IDLE;
			cnt_q <= 16'h0000;
			row_q <= 16'h0000;
		end
		else
		begin
			case (state_q)
				ISP_IDLE:
				begin
					state_q <= ISP_VSYNC;
					cnt_q <= 16'h0000;
				end
				ISP_VSYNC:
					if (cnt_q == 16'(VBLANK - 1))
					begin
						state_q <= ISP_LINE;
						cnt_q <= 16'h0000;
						row_q <= 16'h0000;
					end
					else
						cnt_q <= cnt_q + 16'h0001;
				ISP_LINE:
					if (cnt_q == 16'(WIN_W - 1))
					begin
						cnt_q <= 16'h0000;
						if (row_q == 16'(WIN_H - 1))
							state_q <= ISP_VSYNC;
						else if (LOWLEN == 0)
							row_q <= row_q + 16'h0001;
						else
							state_q <= ISP_HBLANK;
					end
					else
						cnt_q <= cnt_q + 16'h0001;
				ISP_HBLANK:
					if (cnt_q == 16'(LOWLEN - 1))
					begin
						state_q <= ISP_LINE;
						cnt_q <= 16'h0000;
						row_q <= row_q + 16'h0001;
					end
					else
						cnt_q <= cnt_q + 16'h0001;
				default:
					state_q <= ISP_IDLE;
			endcase
		end
	end
	// Test pattern stands in for the ADC; taken from the current count, no extra lag
	function automatic isp_pixel_t test_pattern(input logic [15:0] col, input logic [15:0] row);
		test_pattern = col[7:0] ^ row[7:0];
	endfunction : test_pattern
	// Registered so outputs move after the edge
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pixel_bus <= 8'h00;
			pixel_valid_strobe <= 1'b0;
			frame_sync <= 1'b0;
		end
		else
		begin
			frame_sync <= en_s && state_q == ISP_VSYNC;
			pixel_valid_strobe <= en_s && state_q == ISP_LINE;
			pixel_bus <= (en_s && state_q == ISP_LINE) ? test_pattern(cnt_q, row_q) : 8'h00;
		end
	end
	// Only writes to our address are acked; reads are refused at the address byte
	function automatic logic addr_hit(input logic [7:0] b);
		addr_hit = b[7:1] == `ISP_I2C_ADDR && !b[0];
	endfunction : addr_hit
	// Minimal I2C slave: address match, acks writes, keeps last data byte
	logic scl_d_q, sda_d_q;
	logic busy_q, addr_ok_q, is_addr_q, ack_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	wire logic scl_rise = scl_s && !scl_d_q;
	wire logic scl_fall = !scl_s && scl_d_q;
	wire logic start_c = scl_s && scl_d_q && sda_d_q && !sda_s;
	wire logic stop_c = scl_s && scl_d_q && !sda_d_q && sda_s;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end
		else
		begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
		end
	end
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy_q <= 1'b0;
			addr_ok_q <= 1'b0;
			is_addr_q <= 1'b0;
			ack_q <= 1'b0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			cfg_last_byte <= 8'h00;
			i2c_sda_out <= 1'b0;
			i2c_sda_oe <= 1'b0;
		end
		else if (start_c)
		begin
			busy_q <= 1'b1;
			is_addr_q <= 1'b1;
			addr_ok_q <= 1'b0;
			bit_q <= 4'h0;
			ack_q <= 1'b0;
			i2c_sda_oe <= 1'b0;
		end
		else if (stop_c)
		begin
			busy_q <= 1'b0;
			ack_q <= 1'b0;
			i2c_sda_oe <= 1'b0;
		end
		else if (busy_q && scl_rise && !ack_q)
		begin
			sh_q <= {sh_q[6:0], sda_s};
			bit_q <= bit_q + 4'h1;
		end
		else if (busy_q && scl_fall)
		begin
			if (ack_q)
			begin
				// Ack released; reads not supported, master sees 0xFF
				ack_q <= 1'b0;
				i2c_sda_oe <= 1'b0;
				bit_q <= 4'h0;
				is_addr_q <= 1'b0;
			end
			else if (bit_q == 4'h8)
			begin
				if (is_addr_q)
				begin
					addr_ok_q <= addr_hit(sh_q);
					ack_q <= addr_hit(sh_q);
					i2c_sda_oe <= addr_hit(sh_q);
					if (!addr_hit(sh_q))
						busy_q <= 1'b0;
				end
				else if (addr_ok_q)
				begin
					cfg_last_byte <= sh_q;
					ack_q <= 1'b1;
					i2c_sda_oe <= 1'b1;
				end
				i2c_sda_out <= 1'b0;
			end
		end
	end
endmodule : isp_pixel_port

//--- isp_map.svh
// Constants for the image sensor pixel port
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH
`define ISP_ARRAY_WIDTH 648
`define ISP_ARRAY_HEIGHT 488
`define ISP_WIN_WIDTH 642
`define ISP_WIN_HEIGHT 482
`define ISP_HBLANK_DEF 10
`define ISP_VBLANK_DEF 8
`define ISP_MCLK_MAX_KHZ 15000
`define ISP_RESET_MIN_CYC 8
`define ISP_ENABLE_MIN_CYC 2
`define ISP_PIX_W 8
`define ISP_I2C_ADDR 7'h21
`endif

//--- isp_pkg.sv
// Types for the image sensor pixel port
package isp_pkg;
	typedef enum logic [1:0] {ISP_IDLE, ISP_VSYNC, ISP_LINE, ISP_HBLANK} isp_state_t;
	typedef logic [7:0] isp_pixel_t;
endpackage : isp_pkg

//--- isp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module isp_sync #(
	parameter int WIDTH = 1,
	// Idle level of the pins, so no false edge follows reset
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_q <= RESET_VAL;
			sync_out <= RESET_VAL;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : isp_sync

//--- isp_pixel_port_props.sv
// Pin checker for the pixel port
`timescale 1ns/100ps
module isp_pixel_port_props (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic sensor_enable,
	input wire isp_pkg::isp_pixel_t pixel_bus,
	input wire logic pixel_valid_strobe,
	input wire logic frame_sync,
	input wire logic i2c_sda_out,
	input wire logic i2c_sda_oe
);
	import isp_pkg::*;
	default clocking @(posedge core_clk);
	endclocking
	// Counts match the shrunken bench build
	default disable iff (!resetn || !sensor_enable);
	sequence s_line;
		pixel_valid_strobe [*4] ##1 !pixel_valid_strobe;
	endsequence
	sequence s_quiet;
		!frame_sync && !pixel_valid_strobe;
	endsequence
	chk_frame_start: assert property (
		$rose(sensor_enable) |-> ##4 $rose(frame_sync)) else $error("frame start");
	chk_sync_width: assert property (
		$rose(frame_sync) |-> frame_sync [*2] ##1 !frame_sync) else $error("sync width");
	chk_line_width: assert property (
		$rose(pixel_valid_strobe) |-> s_line) else $error("line width");
	chk_line_gap: assert property (
		$fell(pixel_valid_strobe) && !frame_sync |-> !pixel_valid_strobe [*4]) else $error("line gap");
	chk_frame_gap: assert property (
		$fell(pixel_valid_strobe) && frame_sync |-> !pixel_valid_strobe [*2]) else $error("frame gap");
	chk_bus_idle: assert property (
		!pixel_valid_strobe |-> pixel_bus == 8'h00) else $error("bus idle");
	chk_sync_no_data: assert property (
		frame_sync |-> !pixel_valid_strobe) else $error("sync data");
	chk_sda_low: assert property (
		i2c_sda_oe |-> !i2c_sda_out) else $error("sda high");
	chk_enable_off: assert property (disable iff (!resetn)
		!sensor_enable [*3] |=> s_quiet) else $error("enable off");
	chk_reset_quiet: assert property (disable iff (1'b0)
		!resetn |=> s_quiet and !i2c_sda_oe) else $error("reset");
endmodule : isp_pixel_port_props
bind isp_pixel_port isp_pixel_port_props u_isp_pixel_port_props (.*);

//--- isp_host_model.sv
// Host model: I2C master and pixel counter
`timescale 1ns/100ps
module isp_host_model (
	input wire logic core_clk,
	input wire logic i2c_sda_oe,
	input wire logic i2c_sda_out,
	input wire logic pixel_valid_strobe,
	output logic i2c_scl_in,
	output logic i2c_sda_in,
	output int pix_cnt
);
	logic sda_m = 1'b1;
	// Pull-up wins once the sensor releases
	assign i2c_sda_in = (i2c_sda_oe && !i2c_sda_out) ? 1'b0 : sda_m;
	initial i2c_scl_in = 1'b1;
	initial pix_cnt = 0;
	// Falling edge capture
	always @(negedge core_clk)
		if (pixel_valid_strobe)
			pix_cnt <= pix_cnt + 1;
	task automatic step(input logic c, input logic d);
		@(negedge core_clk);
		i2c_scl_in = c;
		sda_m = d;
		repeat (4) @(negedge core_clk);
	endtask : step
	task automatic write(input logic [6:0] a, input logic [7:0] d, output logic [1:0] ack);
		logic [17:0] b;
		b = {a, 1'b0, 1'b1, d, 1'b1};
		step(1'b1, 1'b0);
		for (int i = 17; i >= 0; i--)
		begin
			step(1'b0, b[i]);
			step(1'b1, b[i]);
			ack[i / 9] = i2c_sda_in;
		end
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask : write
endmodule : isp_host_model

//--- tb.sv
// Testbench for the pixel port
`timescale 1ns/100ps
module tb;
	import isp_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic sensor_enable = 1'b0;
	logic i2c_scl_in, i2c_sda_in, i2c_sda_out, i2c_sda_oe, pixel_valid_strobe, frame_sync;
	isp_pixel_t pixel_bus;
	logic [7:0] cfg_last_byte;
	logic [1:0] ack;
	int pix_cnt, n0, miscompares = 0, samples_checked = 0, cyc = 0;
	initial forever #25 core_clk = ~core_clk;
	isp_pixel_port #(.WIN_W(4), .WIN_H(3), .ARRAY_W(6), .HBLANK(2), .VBLANK(2))
		u_isp_pixel_port (.*);
	isp_host_model u_isp_host_model (.*);
	task automatic check(input string n, input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge core_clk)
		if (++cyc == 20000)
		begin
			miscompares++;
			tally_and_finish();
		end
	task automatic t_frame;
		@(negedge core_clk);
		sensor_enable = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 check("sync early", {7'h00, frame_sync}, 8'h00);
		@(posedge core_clk);
		#1 check("sync", {7'h00, frame_sync}, 8'h01);
		n0 = pix_cnt;
		@(posedge pixel_valid_strobe);
		for (int i = 0; i < 4; i++)
		begin
			@(negedge core_clk);
			check("pixel", pixel_bus, 8'(i));
		end
		@(posedge frame_sync);
		check("frame pixels", 8'(pix_cnt - n0), 8'h0C);
	endtask : t_frame
	task automatic t_i2c;
		u_isp_host_model.write(7'h21, 8'hA5, ack);
		check("ack", {6'h00, ack}, 8'h00);
		check("cfg", cfg_last_byte, 8'hA5);
		u_isp_host_model.write(7'h22, 8'h3C, ack);
		check("nack", {6'h00, ack}, 8'h03);
		check("cfg kept", cfg_last_byte, 8'hA5);
	endtask : t_i2c
	initial
	begin
		repeat (8) @(negedge core_clk);
		resetn = 1'b1;
		@(negedge core_clk);
		check("idle", {5'h00, frame_sync, pixel_valid_strobe, i2c_sda_oe}, 8'h00);
		t_frame();
		t_i2c();
		@(posedge pixel_valid_strobe);
		@(negedge core_clk);
		sensor_enable = 1'b0;
		repeat (4) @(posedge core_clk);
		#1 check("off", {6'h00, frame_sync, pixel_valid_strobe}, 8'h00);
		check("off bus", pixel_bus, 8'h00);
		t_frame();
		tally_and_finish();
	end
endmodule : tb
